// ===== load_pkg.sv
package load_pkg;
  // load kinds
  typedef enum logic [2:0] {
    LD_BYTE_S, LD_BYTE_U, LD_HALF_S, LD_HALF_U, LD_WORD, LD_DOUBLE
  } load_kind_t;

  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int IMM_W = 32;
  localparam int REG_IDX_W = 6;
  localparam int PRED_W = 4;
  localparam logic [REG_IDX_W-1:0] RETURN_ADDR_IDX = 6'h3F;
  // result latency in cycles from issue
  localparam int RESULT_LATENCY = 2;
  // latency before a jump through the return-address register
  localparam int RETURN_REG_JUMP_LATENCY = 3;
  localparam logic [PRED_W-1:0] PRED_FALSE = 4'h0;
  localparam logic [DATA_W-1:0] RESET_WORD = 32'h0000_0000;
endpackage : load_pkg

// ===== load_link_if.sv
`timescale 1ns/10ps
interface load_link_if;
  import load_pkg::*;
  // issue side
  logic issueValid;
  load_kind_t issueKind;
  logic issuePredicated;
  logic [PRED_W-1:0] predicateValue;
  logic [IMM_W-1:0] offsetImmediate;
  logic [DATA_W-1:0] baseValue;
  logic [REG_IDX_W-1:0] destIndex;
  // check answers from the memory side (combinational on address)
  logic [ADDR_W-1:0] checkAddr;
  logic dataBreakpointHit;
  logic controlSpaceHit;
  logic controlSpaceAccessError;
  logic controlSpaceUnmappedError;
  logic dataTranslationError;
  // read request and response
  logic readValid;
  logic readControlSpace;
  load_kind_t readKind;
  logic [ADDR_W-1:0] readAddr;
  logic [2*DATA_W-1:0] readData;

  modport device (
    input issueValid, issueKind, issuePredicated, predicateValue, offsetImmediate,
    input baseValue, destIndex, dataBreakpointHit, controlSpaceHit,
    input controlSpaceAccessError, controlSpaceUnmappedError, dataTranslationError, readData,
    output checkAddr, readValid, readControlSpace, readKind, readAddr
  );
  modport issuer (
    output issueValid, issueKind, issuePredicated, predicateValue, offsetImmediate,
    output baseValue, destIndex, dataBreakpointHit, controlSpaceHit,
    output controlSpaceAccessError, controlSpaceUnmappedError, dataTranslationError, readData,
    input checkAddr, readValid, readControlSpace, readKind, readAddr
  );
endinterface : load_link_if

// ===== load_extend.sv
`timescale 1ns/10ps
module load_extend
  import load_pkg::*;
(
  input load_kind_t kind,
  input logic [2*DATA_W-1:0] raw,
  output logic [2*DATA_W-1:0] extended
);
  // sign or zero extension of the returned data
  always_comb
  begin
    case (kind)
      LD_BYTE_S: extended = {{56{raw[7]}}, raw[7:0]};
      LD_BYTE_U: extended = {56'h0, raw[7:0]};
      LD_HALF_S: extended = {{48{raw[15]}}, raw[15:0]};
      LD_HALF_U: extended = {48'h0, raw[15:0]};
      LD_WORD: extended = {{32{raw[31]}}, raw[31:0]};
      default: extended = raw;
    endcase
  end
endmodule : load_extend

// ===== load_unit.sv
`timescale 1ns/10ps
// Behaviour
// - address is immediate plus base, modulo 2^32
// - zero predicate: no checks, read or write
// - predicate never names condition register zero
// - byte load, sign/zero extend, never misaligned
// - half-word load, extend, may trap misaligned
// - non-word control-space load: access error, no read
// - word control-space load reads control register
// - breakpoint, control space, translation, alignment order
// - double load fills even pair, skip pair zero
// - double destination never pair zero
// - at most one load/store per bundle
// - result readable two cycles after issue
// - narrow loads never target return-address register
// - three cycles before jump through loaded return
module load_unit
  import load_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  load_link_if.device link,
  output logic wbValid,
  output logic [REG_IDX_W-1:0] wbIndex,
  output logic [DATA_W-1:0] wbData,
  output logic wbPairValid,
  output logic [DATA_W-1:0] wbPairData,
  output logic exceptionValid,
  output logic breakpointFault,
  output logic controlAccessFault,
  output logic controlUnmappedFault,
  output logic translationFault,
  output logic alignmentFault
);
  logic [ADDR_W-1:0] effAddr;
  logic active;
  logic misaligned;
  // one flag per check, already masked by the ones above it
  logic bpErr;
  logic csAccErr;
  logic csMapErr;
  logic tlbErr;
  logic alErr;
  logic anyErr;
  localparam int FAULT_N = 5;
  logic [FAULT_N-1:0] faultNow;
  logic [FAULT_N-1:0] fault_reg;
  logic issueRead;
  // answer-cycle context of the read in flight
  logic stage1_reg;
  load_kind_t kind1_reg;
  logic [REG_IDX_W-1:0] dest1_reg;
  logic [2*DATA_W-1:0] extended;

  // both operands come in already sign-extended to 32 bits
  // wrap-around sum, unsigned result
  assign effAddr = link.offsetImmediate + link.baseValue;
  assign link.checkAddr = effAddr;
  // predicated form only acts on a nonzero condition
  // a false predicate also hides every fault, so nothing is raised
  assign active = link.issueValid &&
    (!link.issuePredicated || link.predicateValue != PRED_FALSE);

  // alignment by access size; bytes are never misaligned
  // natural alignment: half on 2, word on 4, double on 8 bytes
  always_comb
  begin
    case (link.issueKind)
      LD_BYTE_S, LD_BYTE_U: misaligned = 1'b0;
      LD_HALF_S, LD_HALF_U: misaligned = effAddr[0];
      LD_WORD: misaligned = |effAddr[1:0];
      LD_DOUBLE: misaligned = |effAddr[2:0];
      default: misaligned = 1'b0;
    endcase
  end

  // checks in priority order; a higher check masks lower ones
  // word loads in control space skip translation and ask the register map
  always_comb
  begin
    bpErr = 1'b0;
    csAccErr = 1'b0;
    csMapErr = 1'b0;
    tlbErr = 1'b0;
    alErr = 1'b0;
    if (active)
    begin
      if (link.dataBreakpointHit)
        bpErr = 1'b1;
      else if (link.controlSpaceHit)
      begin
        if (link.issueKind != LD_WORD)
          csAccErr = 1'b1;
        else if (link.controlSpaceAccessError)
          csAccErr = 1'b1;
        else if (link.controlSpaceUnmappedError)
          csMapErr = 1'b1;
        else if (misaligned)
          alErr = 1'b1;
      end
      else if (link.dataTranslationError)
        tlbErr = 1'b1;
      else if (misaligned)
        alErr = 1'b1;
    end
  end

  // any one of them stops both the read and the write-back
  assign anyErr = bpErr | csAccErr | csMapErr | tlbErr | alErr;

  // the read goes out only once every check has passed
  assign issueRead = active && !anyErr;
  assign link.readValid = issueRead;
  // only word loads get this far inside control space
  assign link.readControlSpace = issueRead && link.controlSpaceHit;
  assign link.readKind = link.issueKind;
  assign link.readAddr = effAddr;

  // fault flags packed so one loop registers them all
  assign faultNow = {bpErr, csAccErr, csMapErr, tlbErr, alErr};

  // exception summary, one cycle after issue
  always_ff @(posedge clk)
  begin
    if (!nrst)
      exceptionValid <= 1'b0;
    else
      exceptionValid <= anyErr;
  end

  // each flag is a one-cycle pulse; all five follow the same template
  generate
    for (genvar i = 0; i < FAULT_N; i++)
    begin : g_fault
      always_ff @(posedge clk)
      begin
        if (!nrst)
          fault_reg[i] <= 1'b0;
        else
          fault_reg[i] <= faultNow[i];
      end
    end
  endgenerate
  // bit order follows the check priority, breakpoint on top
  assign breakpointFault = fault_reg[4];
  assign controlAccessFault = fault_reg[3];
  assign controlUnmappedFault = fault_reg[2];
  assign translationFault = fault_reg[1];
  assign alignmentFault = fault_reg[0];

  // first pipeline stage holds the issued read's context
  // kind and destination ride along so the answer can be extended and routed
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      stage1_reg <= 1'b0;
      kind1_reg <= LD_WORD;
      dest1_reg <= '0;
    end
    else
    begin
      stage1_reg <= issueRead;
      kind1_reg <= link.issueKind;
      dest1_reg <= link.destIndex;
    end
  end

  // extension works on the answer cycle, with the kind kept from issue
  load_extend extender (
    .kind(kind1_reg),
    .raw(link.readData),
    .extended(extended)
  );

  // write-back strobes land two edges after issue; memory answers one cycle after the read
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      wbValid <= 1'b0;
      wbPairValid <= 1'b0;
    end
    else
    begin
      // pair zero writes nothing, hence the gate
      wbValid <= stage1_reg && !(kind1_reg == LD_DOUBLE && dest1_reg == '0);
      wbPairValid <= stage1_reg && kind1_reg == LD_DOUBLE && dest1_reg != '0;
    end
  end

  // write-back data follows the answer every cycle; only the strobes say it is meant
  // no enable on 70 flops, the register file looks at the strobes alone
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      wbIndex <= '0;
      wbData <= RESET_WORD;
      wbPairData <= RESET_WORD;
    end
    else
    begin
      wbIndex <= dest1_reg;
      wbData <= extended[DATA_W-1:0];
      wbPairData <= extended[2*DATA_W-1:DATA_W];
    end
  end
endmodule : load_unit

// ===== load_issuer.sv
`timescale 1ns/10ps
module load_issuer
  import load_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  load_link_if.issuer link,
  input wire logic reqValid,
  input load_kind_t reqKind,
  input wire logic reqPredicated,
  input wire logic [PRED_W-1:0] reqPredicate,
  input wire logic [IMM_W-1:0] reqOffset,
  input wire logic [DATA_W-1:0] reqBase,
  input wire logic [REG_IDX_W-1:0] reqDest,
  output logic reqReady,
  output logic returnJumpAllowed,
  input wire logic memBreakpoint,
  input wire logic memControlSpace,
  input wire logic memControlAccess,
  input wire logic memControlUnmapped,
  input wire logic memTranslation,
  input wire logic [2*DATA_W-1:0] memData,
  output logic [ADDR_W-1:0] memCheckAddr,
  output logic memReadValid,
  output logic memReadControl,
  output logic [ADDR_W-1:0] memReadAddr
);
  logic legal;
  logic [1:0] lrWait_reg;
  logic [1:0] lrWait_next;

  // refuse operand forms that the unit must never see
  always_comb
  begin
    legal = 1'b1;
    if (reqKind == LD_DOUBLE && reqDest == '0)
      legal = 1'b0;
    if (reqKind != LD_WORD && reqKind != LD_DOUBLE && reqDest == RETURN_ADDR_IDX)
      legal = 1'b0;
  end
  assign reqReady = legal;

  // one load per cycle: this port carries a single operation
  assign link.issueValid = reqValid && legal;
  assign link.issueKind = reqKind;
  assign link.issuePredicated = reqPredicated;
  assign link.predicateValue = reqPredicate;
  assign link.offsetImmediate = reqOffset;
  assign link.baseValue = reqBase;
  assign link.destIndex = reqDest;

  // memory side passes straight through
  assign link.dataBreakpointHit = memBreakpoint;
  assign link.controlSpaceHit = memControlSpace;
  assign link.controlSpaceAccessError = memControlAccess;
  assign link.controlSpaceUnmappedError = memControlUnmapped;
  assign link.dataTranslationError = memTranslation;
  assign link.readData = memData;
  assign memCheckAddr = link.checkAddr;
  assign memReadValid = link.readValid;
  assign memReadControl = link.readControlSpace;
  assign memReadAddr = link.readAddr;

  // word load into return register blocks jumps for three cycles
  always_comb
  begin
    lrWait_next = (lrWait_reg != 2'h0) ? lrWait_reg - 2'h1 : 2'h0;
    if (link.issueValid && reqKind == LD_WORD && reqDest == RETURN_ADDR_IDX)
      lrWait_next = 2'(RETURN_REG_JUMP_LATENCY);
  end
  always_ff @(posedge clk)
  begin
    if (!nrst)
      lrWait_reg <= 2'h0;
    else
      lrWait_reg <= lrWait_next;
  end
  assign returnJumpAllowed = (lrWait_reg == 2'h0);
endmodule : load_issuer

// ===== load_link_checker.sv
`timescale 1ns/10ps
module load_link_checker
  import load_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic issueValid,
  input load_kind_t issueKind,
  input wire logic issuePredicated,
  input wire logic [PRED_W-1:0] predicateValue,
  input wire logic [IMM_W-1:0] offsetImmediate,
  input wire logic [DATA_W-1:0] baseValue,
  input wire logic [ADDR_W-1:0] checkAddr,
  input wire logic dataBreakpointHit,
  input wire logic controlSpaceHit,
  input wire logic dataTranslationError,
  input wire logic readValid,
  input wire logic readControlSpace,
  input load_kind_t readKind,
  input wire logic [ADDR_W-1:0] readAddr
);
  // all checks in the core clock domain
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // address, read launch and suppression
  a_addr_sum: assert property (issueValid |-> checkAddr == offsetImmediate + baseValue)
    else $error("effective address not base plus offset");
  a_read_cause: assert property (readValid |-> issueValid && readAddr == checkAddr
    && readKind == issueKind)
    else $error("read request without matching issue");
  a_pred_skip: assert property (issueValid && issuePredicated
    && predicateValue == PRED_FALSE |-> !readValid)
    else $error("read issued under false predicate");
  a_brk_first: assert property (issueValid && dataBreakpointHit |-> !readValid)
    else $error("read issued despite breakpoint hit");
  a_ctrl_narrow: assert property (issueValid && controlSpaceHit
    && issueKind != LD_WORD |-> !readValid)
    else $error("narrow or double read reached control space");
  a_ctrl_word: assert property (readValid && controlSpaceHit
    |-> readControlSpace && issueKind == LD_WORD)
    else $error("control space read not a word read");
  a_trans_stop: assert property (issueValid && dataTranslationError
    && !controlSpaceHit |-> !readValid)
    else $error("read issued despite translation error");
  a_half_align: assert property (issueValid && issueKind inside {LD_HALF_S, LD_HALF_U}
    && checkAddr[0] |-> !readValid)
    else $error("misaligned half read issued");
  a_byte_read: assert property (issueValid && issueKind inside {LD_BYTE_S, LD_BYTE_U}
    && !issuePredicated && !dataBreakpointHit && !controlSpaceHit && !dataTranslationError
    |-> readValid)
    else $error("clean byte load issued no read");
endmodule : load_link_checker

// ===== tb.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin cmpCount++; if ((g) !== (e)) begin errTotal++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module tb;
  import load_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, reqValid = 1'b0, reqPredicated = 1'b0, reqReady, rja, rdy, ctl;
  load_kind_t reqKind = LD_WORD;
  logic [PRED_W-1:0] reqPredicate = 4'h0;
  logic [31:0] reqOffset = 32'h0, reqBase = 32'h0, memCheckAddr, memReadAddr, wbData, wbPairData;
  logic [REG_IDX_W-1:0] reqDest = 6'h0, wbIndex;
  logic [4:0] flg = 5'h0;
  logic [63:0] memData = 64'h0;
  logic returnJumpAllowed, memReadValid, memReadControl, wbValid, wbPairValid, exceptionValid;
  logic [4:0] flt;
  int errTotal = 0, cmpCount = 0, cycles = 0;
  load_link_if link();
  load_unit u_load_unit(.clk(clk), .nrst(nrst), .link(link), .wbValid(wbValid), .wbIndex(wbIndex),
    .wbData(wbData), .wbPairValid(wbPairValid), .wbPairData(wbPairData),
    .exceptionValid(exceptionValid), .breakpointFault(flt[4]), .controlAccessFault(flt[3]),
    .controlUnmappedFault(flt[2]), .translationFault(flt[1]), .alignmentFault(flt[0]));
  load_issuer u_load_issuer(.clk(clk), .nrst(nrst), .link(link), .reqValid(reqValid),
    .reqKind(reqKind), .reqPredicated(reqPredicated), .reqPredicate(reqPredicate),
    .reqOffset(reqOffset), .reqBase(reqBase), .reqDest(reqDest), .reqReady(reqReady),
    .returnJumpAllowed(returnJumpAllowed), .memBreakpoint(flg[4]), .memControlSpace(flg[3]),
    .memControlAccess(flg[2]), .memControlUnmapped(flg[1]), .memTranslation(flg[0]),
    .memData(memData), .memCheckAddr(memCheckAddr), .memReadValid(memReadValid),
    .memReadControl(memReadControl), .memReadAddr(memReadAddr));
  load_link_checker chk(.clk(clk), .nrst(nrst), .issueValid(link.issueValid),
    .issueKind(link.issueKind), .issuePredicated(link.issuePredicated),
    .predicateValue(link.predicateValue), .offsetImmediate(link.offsetImmediate),
    .baseValue(link.baseValue), .checkAddr(link.checkAddr),
    .dataBreakpointHit(link.dataBreakpointHit), .controlSpaceHit(link.controlSpaceHit),
    .dataTranslationError(link.dataTranslationError), .readValid(link.readValid),
    .readControlSpace(link.readControlSpace), .readKind(link.readKind), .readAddr(link.readAddr));
  // 100 ns core clock
  always #50 clk = ~clk;
  // hang guard, the whole run needs well under 200 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      errTotal++;
      printVerdict();
    end
  end
  task automatic printVerdict();
    if (errTotal == 0 && cmpCount > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : printVerdict
  // one load: c0 issue and read, c1 faults, c2 write-back
  task automatic run_load(load_kind_t k, logic p, logic [3:0] pv, logic [31:0] o, b,
    logic [5:0] dst, logic [4:0] f, logic [63:0] d, logic er, logic [4:0] ef, logic ew,
    logic [31:0] lo, hi);
    @(posedge clk);
    reqValid <= 1'b1;
    reqKind <= k;
    {reqPredicated, reqPredicate} <= {p, pv};
    {reqOffset, reqBase, reqDest, flg} <= {o, b, dst, f};
    @(negedge clk);
    rdy = reqReady;
    ctl = memReadControl;
    `CHK("read", er, memReadValid)
    `CHK("check address", o + b, memCheckAddr)
    if (er) `CHK("addr", o + b, memReadAddr)
    @(posedge clk);
    {reqValid, flg, memData} <= {1'b0, 5'h0, d};
    @(negedge clk);
    rja = returnJumpAllowed;
    `CHK("fault", ef, flt)
    `CHK("exception", |ef, exceptionValid)
    @(negedge clk);
    `CHK("wb", ew, wbValid)
    `CHK("pair", ew && k == LD_DOUBLE, wbPairValid)
    if (ew) `CHK("data", lo, wbData)
    if (ew) `CHK("index", dst, wbIndex)
    if (ew && k == LD_DOUBLE) `CHK("upper", hi, wbPairData)
  endtask : run_load
  // extension of narrow loads, wrap of the address sum
  task automatic t_narrow();
    run_load(LD_BYTE_S, 0, 0, 32'hFFFFFFFC, 32'h1001, 6'h05, 0, 64'h1234ABCD9ABCDE80, 1, 0, 1,
      32'hFFFFFF80, 0);
    `CHK("ready", 1'b1, rdy)
    run_load(LD_BYTE_U, 0, 0, 32'h00000001, 32'hFFFFFFFF, 6'h06, 0, 64'h00000000FFFFFFF0, 1, 0, 1,
      32'h000000F0, 0);
    run_load(LD_HALF_S, 0, 0, 32'h2, 32'h100, 6'h07, 0, 64'h0000000012348001, 1, 0, 1,
      32'hFFFF8001, 0);
    run_load(LD_HALF_U, 0, 0, 32'h2, 32'h100, 6'h08, 0, 64'h0000000012348001, 1, 0, 1,
      32'h00008001, 0);
    run_load(LD_HALF_U, 0, 0, 32'h1, 32'h100, 6'h08, 0, 64'h0, 0, 5'h01, 0, 0, 0);
  endtask : t_narrow
  // double pair split and predication
  task automatic t_wide_pred();
    run_load(LD_DOUBLE, 0, 0, 32'h8, 32'h200, 6'h02, 0, 64'h1122334455667788, 1, 0, 1,
      32'h55667788, 32'h11223344);
    run_load(LD_WORD, 1, 4'h0, 32'h4, 32'h300, 6'h09, 0, 64'h0, 0, 0, 0, 0, 0);
    run_load(LD_WORD, 1, 4'h1, 32'h4, 32'h300, 6'h09, 0, 64'hCAFE0001, 1, 0, 1,
      32'hCAFE0001, 0);
  endtask : t_wide_pred
  // control space and check priority
  task automatic t_checks();
    run_load(LD_BYTE_U, 0, 0, 32'h0, 32'h400, 6'h0A, 5'h08, 0, 0, 5'h08, 0, 0, 0);
    run_load(LD_WORD, 0, 0, 32'h0, 32'h400, 6'h0A, 5'h0A, 0, 0, 5'h04, 0, 0, 0);
    run_load(LD_WORD, 0, 0, 32'h0, 32'h400, 6'h0A, 5'h08, 64'h5A5A, 1, 0, 1, 32'h5A5A, 0);
    `CHK("control", 1'b1, ctl)
    run_load(LD_WORD, 0, 0, 32'h0, 32'h400, 6'h0A, 5'h19, 0, 0, 5'h10, 0, 0, 0);
    run_load(LD_BYTE_S, 0, 0, 32'h0, 32'h401, 6'h0A, 5'h01, 0, 0, 5'h02, 0, 0, 0);
  endtask : t_checks
  // illegal forms dropped, return register hold-off
  task automatic t_issuer();
    run_load(LD_DOUBLE, 0, 0, 32'h0, 32'h500, 6'h00, 0, 0, 0, 0, 0, 0, 0);
    `CHK("ready", 1'b0, rdy)
    run_load(LD_BYTE_S, 0, 0, 32'h0, 32'h500, RETURN_ADDR_IDX, 0, 0, 0, 0, 0, 0, 0);
    `CHK("ready", 1'b0, rdy)
    run_load(LD_WORD, 0, 0, 32'h0, 32'h500, RETURN_ADDR_IDX, 0, 64'h80, 1, 0, 1, 32'h80, 0);
    `CHK("jump", 1'b0, rja)
    repeat (3) @(posedge clk);
    @(negedge clk);
    `CHK("jump", 1'b1, returnJumpAllowed)
  endtask : t_issuer
  initial
  begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    t_narrow();
    t_wide_pred();
    t_checks();
    t_issuer();
    printVerdict();
  end
endmodule : tb
